// ---- design/adc_ctrl_pkg.sv ----
// package: register map, field layout and constants of the conversion control block
package adc_ctrl_pkg;
  localparam logic [7:0] ADDR_PRESCALE = 8'h95;
  localparam logic [7:0] ADDR_RESULT = 8'h96;
  localparam logic [7:0] ADDR_CONTROL = 8'h97;
  localparam logic [7:0] RST_PRESCALE = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam int BIT_DONE = 0;
  localparam int BIT_GO = 1;
  localparam int BIT_SEL_LO = 2;
  localparam int BIT_SEL_HI = 3;
  localparam int BIT_POWER = 5;
  localparam int RESULT_BITS = 8;
  localparam int CLOCKS_PER_BIT = 8;
  localparam logic [5:0] CONV_TICKS_LAST = 6'h3f;
  localparam logic [7:0] CONTROL_WMASK = 8'h2c;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic power_on;
    logic [1:0] chan;
    logic sample;
  } analog_ctl_t;
endpackage

// ---- design/conv_clock_div.sv ----
// conversion clock tick generator: system clock halved, then divided by prescale plus one
`timescale 1ns/1ps
`default_nettype none
module conv_clock_div
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic run_i,
  input wire logic [7:0] prescale_i,
  // tick
  output logic tick_o
);
  logic half;
  logic [7:0] cnt;
  logic next_half;
  logic [7:0] next_cnt;
  logic next_tick;

  always_comb
  begin
    next_half = 1'b0;
    next_cnt = 8'h00;
    next_tick = 1'b0;
    if (run_i)
    begin
      next_half = ~half;
      next_cnt = cnt;
      if (half)
      begin
        if (cnt >= prescale_i) // RQ2
        begin
          next_cnt = 8'h00;
          next_tick = 1'b1;
        end
        else
        begin
          next_cnt = cnt + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      half <= 1'b0;
      cnt <= 8'h00;
      tick_o <= 1'b0;
    end
    else
    begin
      half <= next_half;
      cnt <= next_cnt;
      tick_o <= next_tick;
    end
  end

  tick_period_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ2
    tick_o |=> !tick_o)
    else $error("conversion tick faster than half system clock");
endmodule
`default_nettype wire

// ---- design/adc_conv_ctrl.sv ----
// conversion control: special-function registers, timing and completion routing
// Summary of operation
// RQ1 - one of four inputs to 8-bit result
// RQ2 - conversion clock is sysclk/2/(prescale+1)
// RQ3 - software loads prescale for about 6MHz
// RQ4 - start bit begins conversion, self-clears next cycle
// RQ5 - done flag low while busy, set at end
// RQ6 - result loaded together with done flag
// RQ7 - channel field bits 3:2 picks input 0-3
// RQ8 - power bit enables converter, clear shuts off
// RQ9 - conversion lasts 64 conversion clock periods
// RQ10 - routing bit swaps irq-one pin for completion
// RQ11 - completion appears as falling edge
// RQ12 - software sets irq one edge triggered
// RQ13 - software selects analog pin function first
// RQ14 - registers reset to zero
// RQ15 - start ignored while power is off
// RQ16 - channel captured at start, held throughout
`timescale 1ns/1ps
`default_nettype none
module adc_conv_ctrl
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // special-function register port
  input wire sfr_req_t sfr_i,
  output logic [7:0] sfr_rdata_o,
  // analog core
  input wire logic [7:0] sar_code_i,
  output analog_ctl_t analog_o,
  // interrupt routing
  input wire logic done_irq_route_i,
  input wire logic ext_irq_one_i,
  output logic irq_one_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_CONV} conv_state_t;

  conv_state_t state;
  conv_state_t next_state;
  logic [7:0] conv_clock_prescale;
  logic [7:0] conv_result;
  logic conv_power_on;
  logic [1:0] chan_sel;
  logic conv_go;
  logic conv_done_flag;
  logic [1:0] chan_held;
  logic [5:0] ticks;
  logic [7:0] next_prescale;
  logic [7:0] next_result;
  logic next_power_on;
  logic [1:0] next_chan_sel;
  logic next_go;
  logic next_done_flag;
  logic [1:0] next_chan_held;
  logic [5:0] next_ticks;
  logic [7:0] next_rdata;
  analog_ctl_t next_analog;
  logic next_irq_one;
  logic tick;
  logic wr_ctl;
  logic start;
  logic finish;

  conv_clock_div u_div (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(state == ST_CONV),
    .prescale_i(conv_clock_prescale),
    .tick_o(tick)
  );

  assign wr_ctl = sfr_i.wr && (sfr_i.addr == ADDR_CONTROL);
  // a start only counts when the same write also sets the power bit; power already on is not enough
  assign start = wr_ctl && sfr_i.wdata[BIT_GO] && sfr_i.wdata[BIT_POWER]
    && state == ST_IDLE; // RQ4 RQ15
  assign finish = (state == ST_CONV) && tick && (ticks == CONV_TICKS_LAST); // RQ9

  always_comb
  begin
    next_state = state;
    next_prescale = conv_clock_prescale;
    next_result = conv_result;
    next_power_on = conv_power_on;
    next_chan_sel = chan_sel;
    next_go = 1'b0; // RQ4
    next_done_flag = conv_done_flag;
    next_chan_held = chan_held;
    next_ticks = ticks;
    if (sfr_i.wr && sfr_i.addr == ADDR_PRESCALE)
    begin
      next_prescale = sfr_i.wdata;
    end
    if (wr_ctl)
    begin
      next_power_on = sfr_i.wdata[BIT_POWER]; // RQ8
      next_chan_sel = sfr_i.wdata[BIT_SEL_HI:BIT_SEL_LO]; // RQ7
    end
    unique case (state)
      ST_IDLE:
      begin
        if (start)
        begin
          next_state = ST_CONV;
          next_go = 1'b1; // RQ4
          next_done_flag = 1'b0; // RQ5
          next_chan_held = sfr_i.wdata[BIT_SEL_HI:BIT_SEL_LO]; // RQ16
          next_ticks = 6'h00;
        end
      end
      ST_CONV:
      begin
        if (!next_power_on)
        begin
          // power removed mid-conversion aborts; no result is posted
          next_state = ST_IDLE;
        end
        else if (finish)
        begin
          next_state = ST_IDLE;
          next_done_flag = 1'b1; // RQ5 RQ6
          next_result = sar_code_i; // RQ6 RQ1
        end
        else if (tick)
        begin
          next_ticks = ticks + 6'h01; // RQ9
        end
      end
    endcase
  end

  always_comb
  begin
    next_rdata = 8'h00;
    if (sfr_i.rd)
    begin
      unique case (sfr_i.addr)
        ADDR_PRESCALE: next_rdata = conv_clock_prescale;
        ADDR_RESULT: next_rdata = conv_result;
        ADDR_CONTROL: next_rdata = {2'b00, conv_power_on, 1'b0, chan_sel, conv_go,
          conv_done_flag};
        default: next_rdata = 8'h00;
      endcase
    end
    next_analog.power_on = next_power_on; // RQ8
    next_analog.chan = (next_state == ST_CONV) ? next_chan_held : next_chan_sel; // RQ16
    next_analog.sample = next_go;
    // the line is asserted low, so the inverted done flag makes completion a falling edge
    next_irq_one = done_irq_route_i ? ~next_done_flag : ext_irq_one_i; // RQ10 RQ11
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_IDLE;
      conv_clock_prescale <= RST_PRESCALE; // RQ14
      conv_result <= RST_RESULT; // RQ14
      conv_power_on <= RST_CONTROL[BIT_POWER];
      chan_sel <= RST_CONTROL[BIT_SEL_HI:BIT_SEL_LO];
      conv_go <= RST_CONTROL[BIT_GO];
      conv_done_flag <= RST_CONTROL[BIT_DONE];
      chan_held <= 2'b00;
      ticks <= 6'h00;
      sfr_rdata_o <= 8'h00;
      analog_o <= '0;
      irq_one_o <= 1'b1;
    end
    else
    begin
      state <= next_state;
      conv_clock_prescale <= next_prescale;
      conv_result <= next_result;
      conv_power_on <= next_power_on;
      chan_sel <= next_chan_sel;
      conv_go <= next_go;
      conv_done_flag <= next_done_flag;
      chan_held <= next_chan_held;
      ticks <= next_ticks;
      sfr_rdata_o <= next_rdata;
      analog_o <= next_analog;
      irq_one_o <= next_irq_one;
    end
  end

  // assertion helpers: system clocks spent converting, and whether the divisor was
  // rewritten meanwhile; a rewrite moves the end point, so the length check stands aside
  logic [15:0] conv_clocks;
  logic [15:0] next_conv_clocks;
  logic prescale_moved;
  logic next_prescale_moved;

  always_comb
  begin
    next_conv_clocks = conv_clocks;
    next_prescale_moved = prescale_moved;
    if (start)
    begin
      next_conv_clocks = 16'h0000;
      next_prescale_moved = 1'b0;
    end
    else if (state == ST_CONV)
    begin
      // 16 bits hold the longest conversion, 128 * 256 clocks, with room to spare
      next_conv_clocks = conv_clocks + 16'h0001;
      if (sfr_i.wr && sfr_i.addr == ADDR_PRESCALE)
      begin
        next_prescale_moved = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      conv_clocks <= 16'h0000;
      prescale_moved <= 1'b0;
    end
    else
    begin
      conv_clocks <= next_conv_clocks;
      prescale_moved <= next_prescale_moved;
    end
  end

  sequence go_written_s;
    start;
  endsequence

  sequence go_pulse_s;
    conv_go ##1 !conv_go;
  endsequence

  sequence sample_pulse_s;
    analog_o.sample ##1 !analog_o.sample;
  endsequence

  // start and its one-cycle strobes
  go_self_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ4
    go_written_s |=> go_pulse_s)
    else $error("start bit did not self-clear after one cycle");
  go_idle_low_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ4
    !start |=> !conv_go)
    else $error("start bit set without a start");
  sample_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ4
    go_written_s |=> sample_pulse_s)
    else $error("sample strobe not a single cycle at start");
  chan_at_start_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ7 RQ16
    go_written_s |=> analog_o.chan == $past(sfr_i.wdata[BIT_SEL_HI:BIT_SEL_LO]))
    else $error("written channel not passed to the core at start");

  // status flag and result
  busy_flag_low_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ5
    state == ST_CONV |-> !conv_done_flag)
    else $error("done flag high during conversion");
  done_at_end_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ5
    finish && !(wr_ctl && !sfr_i.wdata[BIT_POWER]) |=> conv_done_flag && state == ST_IDLE)
    else $error("done flag not set at the end of a conversion");
  done_stands_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ5
    conv_done_flag && !start |=> conv_done_flag)
    else $error("done flag dropped without a new start");
  result_with_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ6
    $rose(conv_done_flag) |-> conv_result == $past(sar_code_i))
    else $error("result not loaded with done flag");
  result_read_only_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ6
    !finish |=> $stable(conv_result))
    else $error("result changed outside a completion");
  ignore_unpowered_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ15
    wr_ctl && !sfr_i.wdata[BIT_POWER] |=> $stable(conv_done_flag) && $stable(conv_result)
      && state == ST_IDLE)
    else $error("start accepted while unpowered");
  chan_held_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ16
    state == ST_CONV && $past(state) == ST_CONV |-> $stable(analog_o.chan))
    else $error("channel changed during conversion");

  // conversion timing
  min_time_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ9
    go_written_s |=> !conv_done_flag [*8])
    else $error("conversion ended too early");
  conv_length_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ9 RQ2
    finish && !prescale_moved |-> conv_clocks ==
      16'(2 * CLOCKS_PER_BIT * RESULT_BITS) * (16'(conv_clock_prescale) + 16'h0001))
    else $error("conversion length differs from 64 conversion clock periods");
  prescale_load_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ2
    sfr_i.wr && sfr_i.addr == ADDR_PRESCALE |=> conv_clock_prescale == $past(sfr_i.wdata))
    else $error("prescale write not stored");

  // power and interrupt line
  power_follow_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ8
    wr_ctl |=> analog_o.power_on == $past(sfr_i.wdata[BIT_POWER]))
    else $error("analog power differs from power bit");
  irq_route_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ10 RQ11
    done_irq_route_i && $rose(conv_done_flag) |=> !irq_one_o)
    else $error("completion not routed as falling edge");
  irq_fall_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ11
    $past(done_irq_route_i) && $past(done_irq_route_i, 2) && $rose(conv_done_flag)
      |-> $fell(irq_one_o))
    else $error("routed completion did not fall with the done flag");
  irq_pin_pass_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ10
    !done_irq_route_i |=> irq_one_o == $past(ext_irq_one_i))
    else $error("interrupt line does not follow the pin when not routed");
endmodule
`default_nettype wire

// ---- tb/analog_core_model.sv ----
// behavioural analog core: four held input levels, code of the selected one
`timescale 1ns/1ps
`default_nettype none
module analog_core_model
  import adc_ctrl_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // control and levels
  input wire analog_ctl_t ctl_i,
  input wire logic [31:0] levels_i,
  // conversion code
  output logic [7:0] sar_code_o
);
  logic [7:0] junk = 8'h5a;
  // an unpowered core shows a moving pattern, so a stale code cannot pass
  always @(posedge ref_clk_i)
    junk <= ~junk + 8'h01;
  // channel is followed live: holding it during a conversion is the block's job
  assign sar_code_o = ctl_i.power_on ? levels_i[ctl_i.chan*8 +: 8] : junk;
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %0t got %h want %h", $time, g, e); end end
module tb_top;
  import adc_ctrl_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic route = 1'b0;
  logic ext_pin = 1'b1;
  sfr_req_t sfr = '0;
  logic [7:0] rdata, code, p, ctl, want;
  analog_ctl_t actl;
  logic irq;
  logic [31:0] levels = '0;
  logic [7:0] expq[$];
  logic pend = 1'b0;
  logic irq_last = 1'b1;
  logic irq_fell = 1'b0;
  logic fell_clr = 1'b0;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  adc_conv_ctrl dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sfr_i(sfr),
    .sfr_rdata_o(rdata), .sar_code_i(code), .analog_o(actl),
    .done_irq_route_i(route), .ext_irq_one_i(ext_pin), .irq_one_o(irq));
  analog_core_model core_u (.ref_clk_i(ref_clk_i), .ctl_i(actl), .levels_i(levels),
    .sar_code_o(code));
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // requests are held for one edge and not released, so back-to-back stays legal
  task automatic wr(logic [7:0] a, logic [7:0] d);
    sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick(1);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] x);
    expq.push_back(x);
    sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    tick(1);
  endtask
  task automatic idle(int n);
    sfr = '0;
    tick(n);
  endtask
  task automatic give_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // read data is registered: it is due one edge after the read was taken
  always @(negedge ref_clk_i)
  begin
    if (pend)
    begin
      want = expq.pop_front();
      `CHK(rdata, want)
    end
    pend = sfr.rd;
  end
  // interrupt one taken as an edge input, the way software has to set it up
  always @(posedge ref_clk_i)
  begin
    irq_fell <= !fell_clr && (irq_fell || (irq_last && !irq));
    irq_last <= irq;
  end
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  initial
  begin
    void'($urandom(71));
    levels = $urandom;
    p = 8'($urandom_range(3));
    tick(16);
    rst_n_i = 1'b1;
    `CHK(irq, 1'b1)
    `CHK(actl, 4'h0)
    rd(ADDR_PRESCALE, 8'h00);
    rd(ADDR_RESULT, 8'h00);
    rd(ADDR_CONTROL, 8'h00);
    rd(8'h94, 8'h00);
    wr(ADDR_CONTROL, 8'h06);
    rd(ADDR_CONTROL, 8'h04);
    wr(ADDR_RESULT, 8'hff);
    rd(ADDR_RESULT, 8'h00);
    wr(ADDR_PRESCALE, p);
    rd(ADDR_PRESCALE, p);
    for (int ch = 0; ch < 4; ch++)
    begin
      route = ch[0];
      ext_pin = 1'($urandom);
      ctl = 8'h20 | 8'(ch << 2);
      wr(ADDR_CONTROL, ctl | 8'h02);
      `CHK(actl.sample, 1'b1)
      `CHK(actl.chan, 2'(ch))
      rd(ADDR_CONTROL, ctl | 8'h02);
      fell_clr = 1'b1;
      wr(ADDR_CONTROL, ctl ^ 8'h0c);
      fell_clr = 1'b0;
      `CHK(actl.sample, 1'b0)
      `CHK(actl.chan, 2'(ch))
      rd(ADDR_CONTROL, ctl ^ 8'h0c);
      idle(1 + 128 * (p + 1) - 12);
      rd(ADDR_CONTROL, ctl ^ 8'h0c);
      `CHK(irq, route ? 1'b1 : ext_pin)
      `CHK(irq_fell, 1'b0)
      idle(20);
      rd(ADDR_CONTROL, ctl ^ 8'h0d);
      rd(ADDR_RESULT, levels[ch*8 +: 8]);
      idle(2);
      `CHK(irq, route ? 1'b0 : ext_pin)
      `CHK(irq_fell, route)
    end
    wr(ADDR_CONTROL, 8'h22);
    wr(ADDR_CONTROL, 8'h00);
    idle(128 * (p + 1) + 20);
    `CHK(actl.power_on, 1'b0)
    rd(ADDR_CONTROL, 8'h00);
    rd(ADDR_RESULT, levels[31:24]);
    idle(3);
    give_verdict();
  end
endmodule
`undef CHK
`default_nettype wire
